// ===== design/mmcb_params.svh
/*
 constants of the bus signal interface: timing counts, frame lengths,
 lane and pull-up masks; assumes a 200 MHz system clock
*/
`ifndef MMCB_PARAMS_SVH
`define MMCB_PARAMS_SVH

`define MMCB_SYS_NS 5
`define MMCB_HALF_DIV 4'h8
`define MMCB_INIT_NS 1000000
`define MMCB_INIT_CYC (`MMCB_INIT_NS / `MMCB_SYS_NS)
`define MMCB_INIT_CLKS 7'h4A
`define MMCB_BUSY_NS 1000000000
`define MMCB_BUSY_CYC (`MMCB_BUSY_NS / `MMCB_SYS_NS)
`define MMCB_CMD_LAST 6'h2F
`define MMCB_CMD_BITS 6'h30
`define MMCB_PU_W1 8'hFF
`define MMCB_PU_W4 8'hF9
`define MMCB_PU_W8 8'h09
`define MMCB_LANES_W1 8'h01
`define MMCB_LANES_W4 8'h0F
`define MMCB_LANES_W8 8'hFF
`define MMCB_BEATS_W1 4'h8
`define MMCB_BEATS_W4 4'h2
`define MMCB_BEATS_W8 4'h1
`define MMCB_ERASE_BLKS 16'h0010
`define MMCB_WP_ERASE 16'h0004

`endif

// ===== design/mmcb_pkg.sv
/*
 types of the bus signal interface: bus width codes and engine states;
 assumes nothing of its surroundings
*/
package mmcb_pkg;
	typedef enum logic [1:0] {
		MMCB_W1 = 2'b00,
		MMCB_W4 = 2'b01,
		MMCB_W8 = 2'b10
	} mmcb_width_t;
	typedef enum logic [1:0] {
		MMCB_TX_IDLE = 2'b00,
		MMCB_TX_BYTE = 2'b01,
		MMCB_TX_END = 2'b10,
		MMCB_TX_STOP = 2'b11
	} mmcb_tx_t;
	typedef enum logic [1:0] {
		MMCB_RX_IDLE = 2'b00,
		MMCB_RX_BYTE = 2'b01,
		MMCB_RX_END = 2'b10
	} mmcb_rx_t;
endpackage

// ===== design/mmcb_if.sv
/*
 link between host and device: clock, command line, eight data lines;
 resolves line levels from both parties' drivers and the pull-ups
*/
`timescale 1ns/1ps
`default_nettype none
interface mmcb_if;
	logic lclk;
	logic h_cmd_o;
	logic h_cmd_oe;
	logic d_cmd_o;
	logic d_cmd_oe;
	logic [7:0] h_dat_o;
	logic [7:0] h_dat_oe;
	logic [7:0] d_dat_o;
	logic [7:0] d_dat_oe;
	logic [7:0] d_pu_en;
	logic cmd;
	logic [7:0] dat;
	// command line: a low driver wins, else bus pull-up
	assign cmd = ~((h_cmd_oe & ~h_cmd_o) | (d_cmd_oe & ~d_cmd_o));
	// data lines: a driver, else internal pull-up, else low
	assign dat = (h_dat_oe & h_dat_o) | (d_dat_oe & d_dat_o)
		| (~h_dat_oe & ~d_dat_oe & d_pu_en);
	modport host (
		output lclk, h_cmd_o, h_cmd_oe, h_dat_o, h_dat_oe,
		input cmd, dat
	);
	modport device (
		output d_cmd_o, d_cmd_oe, d_dat_o, d_dat_oe, d_pu_en,
		input lclk, cmd, dat
	);
endinterface
`default_nettype wire

// ===== design/mmcb_dat_eng.sv
/*
 data line engine shared by both ends: sends and receives byte blocks
 over 1, 4 or 8 lines; assumes synchronised lines and edge strobes
*/
`timescale 1ns/1ps
`default_nettype none
`include "mmcb_params.svh"
module mmcb_dat_eng (
	// system
	input wire logic sys_clk,
	input wire logic rst_b,
	// link timing
	input wire logic smp,
	input wire logic drv,
	input wire mmcb_pkg::mmcb_width_t width,
	input wire logic [11:0] blk_len,
	// lines
	input wire logic [7:0] dat_in,
	output logic [7:0] dat_o,
	output logic [7:0] dat_oe,
	// send side
	input wire logic tx_go,
	input wire logic [7:0] tx_data,
	output logic tx_take,
	output logic tx_busy,
	// receive side
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_busy
);
	import mmcb_pkg::*;
	mmcb_tx_t tx_st_r;
	mmcb_rx_t rx_st_r;
	logic go_r;
	logic [7:0] tsh_r;
	logic [7:0] rsh_r;
	logic [3:0] tbeat_r;
	logic [3:0] rbeat_r;
	logic [11:0] tcnt_r;
	logic [11:0] rcnt_r;
	logic [3:0] beats;
	logic [7:0] lanes;
	logic [7:0] cur;
	logic [7:0] put;
	logic [7:0] shl;
	logic [7:0] rsh_nxt;

	// lane count per width
	always_comb begin
		cur = (tbeat_r == 4'h0) ? tx_data : tsh_r;
		if (width == MMCB_W8) begin
			beats = `MMCB_BEATS_W8;
			lanes = `MMCB_LANES_W8;
			put = cur;
			shl = 8'h00;
			rsh_nxt = dat_in;
		end else if (width == MMCB_W4) begin
			beats = `MMCB_BEATS_W4;
			lanes = `MMCB_LANES_W4;
			put = {4'h0, cur[7:4]};
			shl = {cur[3:0], 4'h0};
			rsh_nxt = {rsh_r[3:0], dat_in[3:0]};
		end else begin
			beats = `MMCB_BEATS_W1;
			lanes = `MMCB_LANES_W1;
			put = {7'h00, cur[7]};
			shl = {cur[6:0], 1'b0};
			rsh_nxt = {rsh_r[6:0], dat_in[0]};
		end
	end

	// start request held until the sender leaves idle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			go_r <= 1'b0;
		end else if (tx_go) begin
			go_r <= 1'b1;
		end else if (tx_st_r != MMCB_TX_IDLE) begin
			go_r <= 1'b0;
		end
	end

	// sender: start bit, bytes high bits first, end bit, release
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_r <= MMCB_TX_IDLE;
			dat_o <= 8'h00;
			dat_oe <= 8'h00;
			tsh_r <= 8'h00;
			tbeat_r <= 4'h0;
			tcnt_r <= 12'h000;
			tx_take <= 1'b0;
		end else begin
			tx_take <= 1'b0;
			if (drv) begin
				case (tx_st_r)
				MMCB_TX_IDLE: begin
					// own drive only while the other side is silent
					if (go_r && rx_st_r == MMCB_RX_IDLE && blk_len != 12'h000) begin
						tx_st_r <= MMCB_TX_BYTE;
						dat_o <= 8'h00;
						dat_oe <= lanes;
						tcnt_r <= blk_len;
						tbeat_r <= 4'h0;
					end
				end
				MMCB_TX_BYTE: begin
					dat_o <= put;
					tsh_r <= shl;
					tx_take <= (tbeat_r == 4'h0);
					if (tbeat_r == beats - 4'h1) begin
						tbeat_r <= 4'h0;
						tcnt_r <= tcnt_r - 12'h001;
						if (tcnt_r == 12'h001) begin
							tx_st_r <= MMCB_TX_END;
						end
					end else begin
						tbeat_r <= tbeat_r + 4'h1;
					end
				end
				MMCB_TX_END: begin
					dat_o <= lanes;
					tx_st_r <= MMCB_TX_STOP;
				end
				default: begin
					dat_oe <= 8'h00;
					tx_st_r <= MMCB_TX_IDLE;
				end
				endcase
			end
		end
	end

	// receiver: start bit on the first line, then blk_len bytes
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_st_r <= MMCB_RX_IDLE;
			rsh_r <= 8'h00;
			rbeat_r <= 4'h0;
			rcnt_r <= 12'h000;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (smp) begin
				case (rx_st_r)
				MMCB_RX_IDLE: begin
					if (tx_st_r == MMCB_TX_IDLE && !dat_in[0]
						&& blk_len != 12'h000) begin
						rx_st_r <= MMCB_RX_BYTE;
						rcnt_r <= blk_len;
						rbeat_r <= 4'h0;
					end
				end
				MMCB_RX_BYTE: begin
					rsh_r <= rsh_nxt;
					if (rbeat_r == beats - 4'h1) begin
						rx_data <= rsh_nxt;
						rx_valid <= 1'b1;
						rbeat_r <= 4'h0;
						rcnt_r <= rcnt_r - 12'h001;
						if (rcnt_r == 12'h001) begin
							rx_st_r <= MMCB_RX_END;
						end
					end else begin
						rbeat_r <= rbeat_r + 4'h1;
					end
				end
				default: begin
					rx_st_r <= MMCB_RX_IDLE;
				end
				endcase
			end
		end
	end

	// busy flags
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_busy <= 1'b0;
			rx_busy <= 1'b0;
		end else begin
			tx_busy <= tx_go | go_r | (tx_st_r != MMCB_TX_IDLE);
			rx_busy <= (rx_st_r != MMCB_RX_IDLE);
		end
	end
endmodule
`default_nettype wire

// ===== design/mmcb_host.sv
/*
 host end of the bus: makes the link clock by a divider, runs the
 power-up run of ones, sends commands, receives responses, moves data;
 assumes the device end on the other side of mmcb_if
*/
`timescale 1ns/1ps
`default_nettype none
`include "mmcb_params.svh"
module mmcb_host #(
	parameter logic [31:0] INIT_CYC = `MMCB_INIT_CYC
) (
	// system
	input wire logic sys_clk,
	input wire logic rst_b,
	// link
	mmcb_if.host lnk,
	// power and clock
	input wire logic supply_ok,
	input wire logic clk_hold,
	output logic ready,
	// command
	input wire logic [47:0] cmd_word,
	input wire logic cmd_go,
	input wire logic pp_mode,
	output logic cmd_busy,
	output logic [47:0] rsp_word,
	output logic rsp_valid,
	// data
	input wire mmcb_pkg::mmcb_width_t width,
	input wire logic [11:0] blk_len,
	input wire logic tx_go,
	input wire logic [7:0] tx_data,
	output logic tx_take,
	output logic tx_busy,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_busy
);
	import mmcb_pkg::*;
	logic [8:0] s1_r;
	logic [8:0] s2_r;
	logic [3:0] div_r;
	logic clk_r;
	logic smp_r;
	logic drv_r;
	logic [31:0] icyc_r;
	logic [6:0] iclk_r;
	logic go_r;
	logic act_r;
	logic pp_r;
	logic [5:0] tcnt_r;
	logic [47:0] tsh_r;
	logic cmd_o_r;
	logic cmd_oe_r;
	logic rx_r;
	logic [5:0] rcnt_r;
	logic [47:0] rsh_r;
	logic tick;

	assign lnk.lclk = clk_r;
	assign lnk.h_cmd_o = cmd_o_r;
	assign lnk.h_cmd_oe = cmd_oe_r;
	assign tick = (div_r == `MMCB_HALF_DIV - 4'h1);

	// device lines pass two flip-flops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_r <= 9'h1FF;
			s2_r <= 9'h1FF;
		end else begin
			s1_r <= {lnk.cmd, lnk.dat};
			s2_r <= s1_r;
		end
	end

	// clock divider; a hold stops the clock low
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_r <= 4'h0;
			clk_r <= 1'b0;
			smp_r <= 1'b0;
			drv_r <= 1'b0;
		end else begin
			smp_r <= 1'b0;
			drv_r <= 1'b0;
			if (!supply_ok || (clk_hold && !clk_r)) begin
				div_r <= 4'h0;
			end else if (tick) begin
				div_r <= 4'h0;
				clk_r <= ~clk_r;
				smp_r <= ~clk_r;
				drv_r <= clk_r;
			end else begin
				div_r <= div_r + 4'h1;
			end
		end
	end

	// run of ones: at least the 1 ms time and 74 clocks
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			icyc_r <= 32'h0;
			iclk_r <= 7'h00;
			ready <= 1'b0;
		end else if (!supply_ok) begin
			icyc_r <= 32'h0;
			iclk_r <= 7'h00;
			ready <= 1'b0;
		end else begin
			if (icyc_r != INIT_CYC) begin
				icyc_r <= icyc_r + 32'h1;
			end
			if (smp_r && iclk_r != `MMCB_INIT_CLKS) begin
				iclk_r <= iclk_r + 7'h01;
			end
			if (icyc_r == INIT_CYC && iclk_r == `MMCB_INIT_CLKS) begin
				ready <= 1'b1;
			end
		end
	end

	// command sender
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			go_r <= 1'b0;
			act_r <= 1'b0;
			pp_r <= 1'b0;
			tcnt_r <= 6'h00;
			tsh_r <= 48'h0;
			cmd_o_r <= 1'b1;
			cmd_oe_r <= 1'b0;
		end else begin
			if (cmd_go && ready && !go_r && !act_r && !rx_r) begin
				go_r <= 1'b1;
				tsh_r <= cmd_word;
				pp_r <= pp_mode;
			end
			if (drv_r && (go_r || act_r)) begin
				if (go_r) begin
					go_r <= 1'b0;
					act_r <= 1'b1;
					tcnt_r <= 6'h00;
				end
				if (go_r || tcnt_r != `MMCB_CMD_BITS) begin
					cmd_o_r <= pp_r ? tsh_r[47] : 1'b0;
					cmd_oe_r <= pp_r | ~tsh_r[47];
					tsh_r <= {tsh_r[46:0], 1'b1};
					tcnt_r <= (go_r ? 6'h00 : tcnt_r) + 6'h01;
				end else begin
					cmd_o_r <= 1'b1;
					cmd_oe_r <= 1'b0;
					act_r <= 1'b0;
				end
			end
		end
	end

	// response receiver, idle while sending
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_r <= 1'b0;
			rcnt_r <= 6'h00;
			rsh_r <= 48'h0;
			rsp_word <= 48'h0;
			rsp_valid <= 1'b0;
			cmd_busy <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			cmd_busy <= go_r | act_r | rx_r | ~ready;
			if (smp_r && !act_r && !go_r) begin
				if (!rx_r && !s2_r[8]) begin
					rx_r <= 1'b1;
					rcnt_r <= 6'h01;
					rsh_r <= 48'h0;
				end else if (rx_r) begin
					rsh_r <= {rsh_r[46:0], s2_r[8]};
					rcnt_r <= rcnt_r + 6'h01;
					if (rcnt_r == `MMCB_CMD_LAST) begin
						rx_r <= 1'b0;
						rsp_word <= {rsh_r[46:0], s2_r[8]};
						rsp_valid <= 1'b1;
					end
				end
			end
		end
	end

	mmcb_dat_eng u_dat (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.smp(smp_r),
		.drv(drv_r),
		.width(width),
		.blk_len(blk_len),
		.dat_in(s2_r[7:0]),
		.dat_o(lnk.h_dat_o),
		.dat_oe(lnk.h_dat_oe),
		.tx_go(tx_go & ready),
		.tx_data(tx_data),
		.tx_take(tx_take),
		.tx_busy(tx_busy),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.rx_busy(rx_busy)
	);
endmodule
`default_nettype wire

// ===== design/mmcb_device.sv
/*
 device end of the bus: samples the host clock, receives commands,
 answers with responses, moves data, switches the pull-ups by width,
 bounds its power-up busy time; assumes the host end on mmcb_if
*/
`timescale 1ns/1ps
`default_nettype none
`include "mmcb_params.svh"
// Functional notes
// - one bit per line per clock
// - works at any clock rate, even stopped
// - command line open-drain or push-pull, shared mode
// - host commands, device only answers them
// - data lines never driven by both
// - all data pull-ups on at default width
// - four lines: drop pull-ups on lines 1, 2
// - eight lines: drop pull-ups 1, 2, 4-7
// - reset leaves only line 0 in use
// - width is one, four or eight lines
// - host waits for stable supplies
// - host sends power-up run of ones
// - power-up done within one second
// - data moves in whole bytes
// - block size fixed or programmable, reported
// - erase group size reported; here ERASE_BLKS reaches no port
// - protect group is whole erase groups
// - busy flag low until power-up done
module mmcb_device #(
	parameter logic [31:0] BUSY_MAX = `MMCB_BUSY_CYC
) (
	// system
	input wire logic sys_clk,
	input wire logic rst_b,
	// link
	mmcb_if.device lnk,
	// command
	output logic [47:0] cmd_word,
	output logic cmd_valid,
	input wire logic [47:0] rsp_word,
	input wire logic rsp_go,
	input wire logic pp_mode,
	output logic rsp_busy,
	// data
	input wire logic [11:0] blk_len,
	input wire logic tx_go,
	input wire logic [7:0] tx_data,
	output logic tx_take,
	output logic tx_busy,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_busy,
	// configuration and power-up
	input wire logic width_set,
	input wire mmcb_pkg::mmcb_width_t width_sel,
	input wire logic hw_reset,
	input wire logic init_start,
	input wire logic init_done,
	output logic ocr_ready,
	output mmcb_pkg::mmcb_width_t bus_width
);
	import mmcb_pkg::*;
	logic [9:0] s1_r;
	logic [9:0] s2_r;
	logic lclk_q_r;
	logic lclk_s;
	logic cmd_s;
	logic [7:0] dat_s;
	logic smp;
	logic drv;
	logic rx_r;
	logic [5:0] rcnt_r;
	logic [47:0] rsh_r;
	logic pend_r;
	logic go_r;
	logic act_r;
	logic pp_r;
	logic [5:0] tcnt_r;
	logic [47:0] tsh_r;
	logic cmd_o_r;
	logic cmd_oe_r;
	logic [7:0] pu_r;
	logic brun_r;
	logic [31:0] bcnt_r;
	// erase and protect group sizes, local to this module; no port carries them out
	localparam logic [15:0] ERASE_BLKS = `MMCB_ERASE_BLKS;
	localparam logic [31:0] WP_BLKS = ERASE_BLKS * `MMCB_WP_ERASE;

	assign lnk.d_cmd_o = cmd_o_r;
	assign lnk.d_cmd_oe = cmd_oe_r;
	assign lnk.d_pu_en = pu_r;
	assign lclk_s = s2_r[9];
	assign cmd_s = s2_r[8];
	assign dat_s = s2_r[7:0];

	// link pins pass two flip-flops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_r <= 10'h1FF;
			s2_r <= 10'h1FF;
		end else begin
			s1_r <= {lnk.lclk, lnk.cmd, lnk.dat};
			s2_r <= s1_r;
		end
	end

	// edge strobes; nothing waits on the link clock
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			lclk_q_r <= 1'b0;
		end else begin
			lclk_q_r <= lclk_s;
		end
	end
	assign smp = lclk_s & ~lclk_q_r;
	assign drv = ~lclk_s & lclk_q_r;

	// command receiver: start bit, then 47 more bits
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_r <= 1'b0;
			rcnt_r <= 6'h00;
			rsh_r <= 48'h0;
			cmd_word <= 48'h0;
			cmd_valid <= 1'b0;
		end else begin
			cmd_valid <= 1'b0;
			if (smp && !act_r) begin
				if (!rx_r && !cmd_s) begin
					rx_r <= 1'b1;
					rcnt_r <= 6'h01;
					rsh_r <= 48'h0;
				end else if (rx_r) begin
					rsh_r <= {rsh_r[46:0], cmd_s};
					rcnt_r <= rcnt_r + 6'h01;
					if (rcnt_r == `MMCB_CMD_LAST) begin
						rx_r <= 1'b0;
						cmd_word <= {rsh_r[46:0], cmd_s};
						cmd_valid <= 1'b1;
					end
				end
			end
		end
	end

	// answer owed: set by a command, cleared when a response starts
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_r <= 1'b0;
		end else if (cmd_valid) begin
			pend_r <= 1'b1;
		end else if (rsp_go && pend_r && !go_r && !act_r) begin
			pend_r <= 1'b0;
		end
	end

	// response sender in the mode the host set
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			go_r <= 1'b0;
			act_r <= 1'b0;
			pp_r <= 1'b0;
			tcnt_r <= 6'h00;
			tsh_r <= 48'h0;
			cmd_o_r <= 1'b1;
			cmd_oe_r <= 1'b0;
		end else begin
			if (rsp_go && pend_r && !go_r && !act_r) begin
				go_r <= 1'b1;
				tsh_r <= rsp_word;
				pp_r <= pp_mode;
			end
			if (drv && !rx_r && (go_r || act_r)) begin
				if (go_r) begin
					go_r <= 1'b0;
					act_r <= 1'b1;
				end
				if (go_r || tcnt_r != `MMCB_CMD_BITS) begin
					cmd_o_r <= pp_r ? tsh_r[47] : 1'b0;
					cmd_oe_r <= pp_r | ~tsh_r[47];
					tsh_r <= {tsh_r[46:0], 1'b1};
					tcnt_r <= (go_r ? 6'h00 : tcnt_r) + 6'h01;
				end else begin
					cmd_o_r <= 1'b1;
					cmd_oe_r <= 1'b0;
					act_r <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rsp_busy <= 1'b0;
		end else begin
			rsp_busy <= go_r | act_r;
		end
	end

	// bus width and pull-ups change together
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_width <= MMCB_W1;
			pu_r <= `MMCB_PU_W1;
		end else if (hw_reset) begin
			bus_width <= MMCB_W1;
			pu_r <= `MMCB_PU_W1;
		end else if (width_set) begin
			case (width_sel)
			MMCB_W1: begin
				bus_width <= MMCB_W1;
				pu_r <= `MMCB_PU_W1;
			end
			MMCB_W4: begin
				bus_width <= MMCB_W4;
				pu_r <= `MMCB_PU_W4;
			end
			MMCB_W8: begin
				bus_width <= MMCB_W8;
				pu_r <= `MMCB_PU_W8;
			end
			default: begin
				bus_width <= bus_width;
			end
			endcase
		end
	end

	// power-up busy: ready on core done or at the time bound
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			brun_r <= 1'b0;
			bcnt_r <= 32'h0;
			ocr_ready <= 1'b0;
		end else if (hw_reset) begin
			brun_r <= 1'b0;
			bcnt_r <= 32'h0;
			ocr_ready <= 1'b0;
		end else if (brun_r) begin
			bcnt_r <= bcnt_r + 32'h1;
			if (init_done || bcnt_r == BUSY_MAX - 32'h1) begin
				brun_r <= 1'b0;
				ocr_ready <= 1'b1;
			end
		end else if (init_start && !ocr_ready) begin
			brun_r <= 1'b1;
			bcnt_r <= 32'h0;
		end
	end

	// block length in bytes comes from the layer that holds it
	mmcb_dat_eng u_dat (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.smp(smp),
		.drv(drv),
		.width(bus_width),
		.blk_len(blk_len),
		.dat_in(dat_s),
		.dat_o(lnk.d_dat_o),
		.dat_oe(lnk.d_dat_oe),
		.tx_go(tx_go),
		.tx_data(tx_data),
		.tx_take(tx_take),
		.tx_busy(tx_busy),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.rx_busy(rx_busy)
	);
endmodule
`default_nettype wire

// ===== sim/mmcb_bus_properties.sv
/*
 concurrent checks on the host-device link signals;
 assumes the testbench places it beside the link interface
*/
`timescale 1ns/1ps
`default_nettype none
module mmcb_bus_props (
	// system
	input wire logic sys_clk,
	input wire logic rst_b,
	// link
	input wire logic lclk,
	input wire logic h_cmd_o,
	input wire logic h_cmd_oe,
	input wire logic d_cmd_oe,
	input wire logic [7:0] h_dat_o,
	input wire logic [7:0] h_dat_oe,
	input wire logic [7:0] d_dat_o,
	input wire logic [7:0] d_dat_oe,
	input wire logic [7:0] d_pu_en
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	AST_DAT_EXCL: assert property
		((h_dat_oe & d_dat_oe) == 8'h00)
		else $error("data line driven by both ends");
	AST_CMD_EXCL: assert property (!(h_cmd_oe && d_cmd_oe))
		else $error("command line driven by both ends");
	AST_PU_CODE: assert property
		(d_pu_en inside {8'hFF, 8'hF9, 8'h09})
		else $error("pull-up set not of a known width");
	AST_PU_KEEP: assert property (d_pu_en[3] && d_pu_en[0])
		else $error("line 0 or 3 pull-up dropped");
	AST_PU_RST: assert property ($rose(rst_b) |-> d_pu_en == 8'hFF)
		else $error("pull-ups not all on after reset");
	AST_LCLK_HIGH: assert property
		($rose(lclk) |-> lclk[*8] ##1 !lclk)
		else $error("link clock high phase not eight cycles");
	AST_HCMD_STABLE: assert property ($rose(lclk) |=>
		($stable(h_cmd_o) && $stable(h_cmd_oe))[*6])
		else $error("host command bit moved in high phase");
	AST_HDAT_STABLE: assert property ($rose(lclk) |=>
		($stable(h_dat_o) && $stable(h_dat_oe))[*6])
		else $error("host data moved in high phase");
	AST_DDAT_STABLE: assert property ($rose(lclk) |=>
		($stable(d_dat_o) && $stable(d_dat_oe))[*6])
		else $error("device data moved in high phase");
	AST_HOE_LANES: assert property
		(h_dat_oe inside {8'h00, 8'h01, 8'h0F, 8'hFF})
		else $error("host drives an odd lane set");
	AST_DOE_LANES: assert property
		(d_dat_oe inside {8'h00, 8'h01, 8'h0F, 8'hFF})
		else $error("device drives an odd lane set");
endmodule
`default_nettype wire

// ===== sim/tb_mmc_bus_signal_interface.sv
/*
 testbench of the bus signal interface: host and device ends joined
 by the link; assumes the design files are compiled before it
*/
`timescale 1ns/1ps
`default_nettype none
module tb_mmc_bus_signal_interface;
	import mmcb_pkg::*;
	localparam int BUSY = 200;
	logic sys_clk = 1'b0, rst_b = 1'b0, supply_ok = 1'b1;
	logic clk_hold = 1'b0, pp_mode = 1'b0, cmd_go = 1'b0, rsp_go = 1'b0;
	logic h_tx_go = 1'b0, d_tx_go = 1'b0, width_set = 1'b0;
	logic hw_reset = 1'b0, init_start = 1'b0, init_done = 1'b0;
	logic [47:0] h_cmd_word = 48'h0, d_rsp_word = 48'h0;
	logic [11:0] blk_len = 12'h001;
	logic [7:0] tx_data = 8'h00;
	mmcb_width_t h_width = MMCB_W1, width_sel = MMCB_W1;
	logic h_ready, h_rsp_valid, h_tx_take, h_rx_valid;
	logic d_cmd_valid, d_tx_take, d_rx_valid, ocr_ready;
	logic h_cmd_busy, h_tx_busy, h_rx_busy, d_rsp_busy, d_tx_busy, d_rx_busy;
	logic [47:0] h_rsp_word, d_cmd_word;
	logic [7:0] h_rx_data, d_rx_data;
	mmcb_width_t bus_width;
	int err_total = 0, checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	mmcb_if u_mmcb_if ();
	mmcb_host #(.INIT_CYC(32'h64)) u_mmcb_host (.sys_clk, .rst_b,
		.lnk(u_mmcb_if.host), .supply_ok, .clk_hold, .ready(h_ready),
		.cmd_word(h_cmd_word), .cmd_go, .pp_mode, .cmd_busy(h_cmd_busy),
		.rsp_word(h_rsp_word), .rsp_valid(h_rsp_valid), .width(h_width),
		.blk_len, .tx_go(h_tx_go), .tx_data, .tx_take(h_tx_take),
		.tx_busy(h_tx_busy), .rx_data(h_rx_data), .rx_valid(h_rx_valid),
		.rx_busy(h_rx_busy));
	mmcb_device #(.BUSY_MAX(32'hC8)) u_mmcb_device (.sys_clk, .rst_b,
		.lnk(u_mmcb_if.device), .cmd_word(d_cmd_word),
		.cmd_valid(d_cmd_valid), .rsp_word(d_rsp_word), .rsp_go, .pp_mode,
		.rsp_busy(d_rsp_busy), .blk_len, .tx_go(d_tx_go), .tx_data,
		.tx_take(d_tx_take), .tx_busy(d_tx_busy), .rx_data(d_rx_data),
		.rx_valid(d_rx_valid), .rx_busy(d_rx_busy), .width_set, .width_sel,
		.hw_reset, .init_start, .init_done, .ocr_ready, .bus_width);
	mmcb_bus_props u_mmcb_bus_props (.sys_clk, .rst_b,
		.lclk(u_mmcb_if.lclk), .h_cmd_o(u_mmcb_if.h_cmd_o),
		.h_cmd_oe(u_mmcb_if.h_cmd_oe), .d_cmd_oe(u_mmcb_if.d_cmd_oe),
		.h_dat_o(u_mmcb_if.h_dat_o), .h_dat_oe(u_mmcb_if.h_dat_oe),
		.d_dat_o(u_mmcb_if.d_dat_o), .d_dat_oe(u_mmcb_if.d_dat_oe),
		.d_pu_en(u_mmcb_if.d_pu_en));
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// sel 0: device command, 1: host response, 2: host ready
	task automatic wait_for(input int sel);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (n < 3000 && !(sel == 0 ? d_cmd_valid === 1'b1 :
			sel == 1 ? h_rsp_valid === 1'b1 : h_ready === 1'b1));
		chk(48'(n < 3000), 48'h1);
	endtask
	task automatic t_cmd(input logic pp, input logic [47:0] word);
		@(posedge sys_clk);
		pp_mode <= pp;
		wait_for(2);
		@(posedge sys_clk);
		h_cmd_word <= word;
		cmd_go <= 1'b1;
		@(posedge sys_clk);
		cmd_go <= 1'b0;
		wait_for(0);
		chk(d_cmd_word, word);
		chk(h_cmd_busy, 1'b1);
		repeat (16) @(posedge sys_clk);
		d_rsp_word <= ~word & 48'h7FFF_FFFF_FFFF;
		rsp_go <= 1'b1;
		@(posedge sys_clk);
		rsp_go <= 1'b0;
		wait_for(1);
		chk(h_rsp_word, ~word & 48'h7FFF_FFFF_FFFF);
		chk(d_rsp_busy, 1'b1);
		repeat (48) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({h_cmd_busy, d_rsp_busy}, 2'b00);
	endtask
	task automatic set_width(input logic [1:0] code, input logic [7:0] pu,
		input logic [1:0] bw);
		@(posedge sys_clk);
		width_sel <= mmcb_width_t'(code);
		width_set <= 1'b1;
		if (code != 2'b11) h_width <= mmcb_width_t'(code);
		@(posedge sys_clk);
		width_set <= 1'b0;
		@(negedge sys_clk);
		chk(u_mmcb_if.d_pu_en, pu);
		chk(bus_width, bw);
	endtask
	// dev 1: device sends; hold: cycle at which the clock is held
	task automatic xfer(input logic dev, input int n, input int hold);
		int t, k, c;
		t = 0;
		k = 0;
		c = 0;
		@(posedge sys_clk);
		blk_len <= 12'(n);
		tx_data <= 8'h96;
		if (dev) d_tx_go <= 1'b1;
		else h_tx_go <= 1'b1;
		@(posedge sys_clk);
		d_tx_go <= 1'b0;
		h_tx_go <= 1'b0;
		while (k < n && c < 4000) begin
			@(negedge sys_clk);
			c++;
			if ((dev ? h_rx_valid : d_rx_valid) === 1'b1) begin
				chk(dev ? h_rx_data : d_rx_data, 8'h96 + 8'(k) * 8'h1D);
				k++;
				if (k == n) begin
					chk({dev ? d_tx_busy : h_tx_busy,
						dev ? h_rx_busy : d_rx_busy}, 2'b11);
				end
			end
			if ((dev ? d_tx_take : h_tx_take) === 1'b1) t++;
			@(posedge sys_clk);
			tx_data <= 8'h96 + 8'(t) * 8'h1D;
			clk_hold <= (c > hold && c < hold + 300);
		end
		chk(48'(k), 48'(n));
		clk_hold <= 1'b0;
		repeat (48) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({h_tx_busy, d_tx_busy, h_rx_busy, d_rx_busy}, 4'h0);
	endtask
	task automatic t_busy;
		@(posedge sys_clk);
		init_start <= 1'b1;
		@(posedge sys_clk);
		init_start <= 1'b0;
		repeat (BUSY - 10) @(negedge sys_clk);
		chk(ocr_ready, 1'b0);
		repeat (20) @(negedge sys_clk);
		chk(ocr_ready, 1'b1);
		@(posedge sys_clk);
		hw_reset <= 1'b1;
		@(posedge sys_clk);
		hw_reset <= 1'b0;
		@(negedge sys_clk);
		chk(ocr_ready, 1'b0);
		@(posedge sys_clk);
		init_start <= 1'b1;
		@(posedge sys_clk);
		init_start <= 1'b0;
		repeat (20) @(posedge sys_clk);
		init_done <= 1'b1;
		@(posedge sys_clk);
		init_done <= 1'b0;
		@(negedge sys_clk);
		chk(ocr_ready, 1'b1);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(negedge sys_clk);
		chk(u_mmcb_if.d_pu_en, 8'hFF);
		chk(bus_width, MMCB_W1);
		chk(ocr_ready, 1'b0);
		repeat (1100) @(negedge sys_clk);
		chk({h_ready, u_mmcb_if.cmd}, 2'b01);
		t_cmd(1'b0, 48'h3A5C_0F0F_1235);
		t_cmd(1'b1, 48'h0123_4567_89AB);
		set_width(2'b01, 8'hF9, 2'b01);
		xfer(1'b0, 3, 99999);
		xfer(1'b1, 3, 99999);
		set_width(2'b11, 8'hF9, 2'b01);
		set_width(2'b10, 8'h09, 2'b10);
		xfer(1'b0, 4, 99999);
		xfer(1'b1, 4, 99999);
		set_width(2'b00, 8'hFF, 2'b00);
		xfer(1'b0, 2, 100);
		xfer(1'b1, 2, 99999);
		set_width(2'b10, 8'h09, 2'b10);
		@(posedge sys_clk);
		hw_reset <= 1'b1;
		h_width <= MMCB_W1;
		@(posedge sys_clk);
		hw_reset <= 1'b0;
		@(negedge sys_clk);
		chk(bus_width, MMCB_W1);
		chk(u_mmcb_if.d_pu_en, 8'hFF);
		xfer(1'b1, 2, 99999);
		t_busy;
		end_sim;
	end
	initial begin
		#400000;
		err_total++;
		end_sim;
	end
endmodule
`default_nettype wire
